//--- common/sfg_link_if.sv
// sfg_link_if: decoded serial frame events passed from the receiver to the guard core.
// assumes: both ends on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface sfg_link_if;
  logic frame_start; // pulse, chip select fell
  logic frame_end; // pulse, chip select rose
  logic sck_fall; // pulse, serial clock fell inside frame
  logic byte_valid; // pulse, rx_byte complete
  logic [7:0] rx_byte;
  logic [2:0] byte_cnt; // bytes finished in frame, saturates at 7
  logic aligned; // no partial byte pending
  logic wp_n; // synchronised write-protect pin
  modport rx (output frame_start, frame_end, sck_fall, byte_valid, rx_byte, byte_cnt, aligned, wp_n);
  modport core (input frame_start, frame_end, sck_fall, byte_valid, rx_byte, byte_cnt, aligned, wp_n);
endinterface
`default_nettype wire

//--- common/sfg_pkg.sv
// sfg_pkg: shared constants of the status and write-protection guard of a serial flash.
// assumes: one 20 MHz system clock; opcode values are local choices.
package sfg_pkg;

  // system clock rate
  localparam int CLK_MHZ = 20;

  // instruction opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_CONFIG_READ = 8'h35;
  localparam logic [7:0] OP_REGISTER_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_PARAM_ERASE_SMALL = 8'h20;
  localparam logic [7:0] OP_PARAM_ERASE_LARGE = 8'h40;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
  localparam logic [7:0] OP_ONE_TIME_PROGRAM = 8'h42;
  localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;

  // status byte field positions
  localparam int ST_BUSY = 0;
  localparam int ST_WRITE_LATCH = 1;
  localparam int ST_PROT_LSB = 2;
  localparam int ST_PROT_MSB = 4;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_PROG_ERR = 6;
  localparam int ST_REG_WRITE_DISABLE = 7;

  // configuration byte field positions, reserved bits read zero
  localparam int CF_QUAD = 1;
  localparam int CF_PARAM_PLACEMENT = 2;
  localparam int CF_PROT_VOLATILITY = 3;
  localparam int CF_PROT_ORIGIN = 5;
  localparam logic [7:0] CF_MASK = 8'h2E;
  localparam logic [7:0] CF_RESET = 8'h00;
  localparam logic [2:0] PROT_RESET = 3'h0;

  // frame byte counts per command
  localparam logic [2:0] LEN_SINGLE = 3'h1;
  localparam logic [2:0] LEN_ADDR = 3'h4;
  localparam logic [2:0] LEN_WRR_ST = 3'h2;
  localparam logic [2:0] LEN_WRR_BOTH = 3'h3;

  // self-timed operation durations in microseconds, and cycle counts
  localparam int WRR_TIME_US = 50;
  localparam int PROG_TIME_US = 100;
  localparam int ERASE_TIME_US = 200;
  localparam int WRR_CYC = WRR_TIME_US * CLK_MHZ;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int OP_CNT_W = 16;

  // kind of self-timed operation
  typedef enum logic [1:0] {OPK_REG, OPK_PROG, OPK_ERASE} sfg_opk_t;

endpackage

//--- hw/sfg_guard.sv
// sfg_guard: status byte, write latch and write protection of a serial flash, mode-0 serial port.
// assumes: array program/erase internals outside; they report failure on the fail inputs.
// Summary of operation
// (RQ1) write-disable clears the write latch, blocking all program, erase and register writes
// (RQ2) host sends write-disable alone inside one chip-select frame
// (RQ3) latch clears at power-up and at completion of write-disable, register write, program, erase
// (RQ4) status read is served at any time, even while busy
// (RQ5) status byte repeats on serial output while chip select stays low
// (RQ6) host polls the busy flag before new commands
// (RQ7) status layout: 7 write disable, 6 prog err, 5 erase err, 4..2 protect, 1 latch, 0 busy
// (RQ8) busy flag is read-only, high during register write, program or erase
// (RQ9) write-enable sets the latch; modifying commands run only with latch set
// (RQ10) register write never changes the latch directly
// (RQ11) protect field volatile or non-volatile per configuration volatility bit
// (RQ12) nonzero protect field blocks program and erase in the protected area
// (RQ13) bulk erase runs only when the protect field is zero
// (RQ14) protect field defaults to 000
// (RQ15) erase error set on failed erase, cleared only by clear-status
// (RQ16) program error set on failed program, cleared only by clear-status
// (RQ17) write-disable bit set and protect pin low lock out register writes
// (RQ18) locked mode makes protect, write-disable and configuration bits read-only
// (RQ19) attempts at protected areas never set error flags
// (RQ20) configuration read is served at any time, even while busy
// (RQ21) configuration byte initially 00h
// (RQ22) locked mode ends only when protect pin goes high; entry in either order
// (RQ23) reserved bits read zero; register write leaves error and busy flags alone
// (RQ24) quad bit set disables locked mode
// (RQ25) 8-bit instructions msb first; replies msb first; output disabled otherwise
// (RQ26) write-disable acts only if chip select rises right after the instruction byte
`timescale 1ns/1ps
`default_nettype none
module sfg_guard
  import sfg_pkg::*;
#(
  parameter int WRR_CYCLES = WRR_CYC,
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire logic WP_N_I,
  input wire logic PROG_FAIL_I,
  input wire logic ERASE_FAIL_I,
  output logic SO_O,
  output logic SO_OE_O,
  output logic BUSY_O
);

  // refuse durations the counter cannot hold
  if (WRR_CYCLES < 1 || PROG_CYCLES < 1 || ERASE_CYCLES < 1 ||
      WRR_CYCLES >= (1 << OP_CNT_W) || PROG_CYCLES >= (1 << OP_CNT_W) ||
      ERASE_CYCLES >= (1 << OP_CNT_W)) begin : g_bad_cycles
    $error("sfg_guard: operation cycle counts out of range");
  end

  typedef enum logic [1:0] {RD_NONE, RD_STATUS, RD_CONFIG} sfg_rd_t;
  typedef enum logic {OP_IDLE, OP_RUN} sfg_op_t;

  sfg_link_if lnk ();

  logic [7:0] cmd_reg;
  logic [23:0] addr_reg;
  logic [7:0] wrr_st_reg;
  logic [7:0] wrr_cf_reg;
  logic wrr_both_reg;
  logic write_latch_reg;
  logic [2:0] prot_nv_reg;
  logic [2:0] prot_vol_reg;
  logic reg_write_disable_reg;
  logic [7:0] cfg_reg;
  logic prog_err_reg;
  logic erase_err_reg;
  sfg_op_t op_state_reg;
  sfg_opk_t op_kind_reg;
  logic [OP_CNT_W-1:0] op_cnt_reg;
  sfg_rd_t rd_mode_reg;
  logic [2:0] tx_cnt_reg;
  logic [6:0] tx_shift_reg;
  logic [2:0] prot_field;
  logic busy;
  logic hw_locked;
  logic area_protected;
  logic op_done;
  logic [7:0] status_byte;
  logic [7:0] config_byte;
  logic do_exec;
  logic start_any;
  logic one_byte_cmd;
  logic clear_status_hit;
  logic start_wrr;
  logic start_prog;
  logic start_erase;
  logic [OP_CNT_W-1:0] op_len;
  logic [5:0] blk_idx;
  logic [5:0] blk_span;

  sfg_spi_rx u_rx (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .sck_i(SCK_I),
    .cs_n_i(CS_N_I),
    .si_i(SI_I),
    .wp_n_i(WP_N_I),
    .lnk(lnk)
  );

  // visible protect field follows the volatility choice
  assign prot_field = cfg_reg[CF_PROT_VOLATILITY] ? prot_vol_reg : prot_nv_reg; // RQ11
  assign busy = (op_state_reg == OP_RUN); // RQ8
  // locked mode is a pure level of bit and pin, so entry order is free and exit needs the pin high
  assign hw_locked = reg_write_disable_reg & ~lnk.wp_n & ~cfg_reg[CF_QUAD]; // RQ17 RQ22 RQ24

  // assembled read-back bytes, reserved bits zero
  assign status_byte = {reg_write_disable_reg, prog_err_reg, erase_err_reg, prot_field,
                        write_latch_reg, busy}; // RQ7
  assign config_byte = cfg_reg & CF_MASK; // RQ23

  // protected region: 2^(field-1) of 64 blocks from top, whole array at 7, origin bit flips to bottom
  assign blk_idx = cfg_reg[CF_PROT_ORIGIN] ? ~addr_reg[21:16] : addr_reg[21:16];
  assign blk_span = 6'(6'h01 << (prot_field - 3'h1));
  assign area_protected = (prot_field == 3'h7) ||
                          ((prot_field != 3'h0) && (blk_idx >= 6'(7'h40 - {1'b0, blk_span}))); // RQ12

  // a command executes only when the frame ends on a byte boundary
  assign do_exec = lnk.frame_end & lnk.aligned; // RQ26
  assign start_wrr = do_exec && !busy && write_latch_reg && !hw_locked && (cmd_reg == OP_REGISTER_WRITE) &&
                     (lnk.byte_cnt == LEN_WRR_ST || lnk.byte_cnt == LEN_WRR_BOTH); // RQ9 RQ17
  assign start_prog = do_exec && !busy && write_latch_reg && lnk.byte_cnt > LEN_ADDR &&
                      (((cmd_reg == OP_PAGE_PROGRAM || cmd_reg == OP_QUAD_PAGE_PROGRAM) && !area_protected) ||
                       cmd_reg == OP_ONE_TIME_PROGRAM); // RQ9 RQ12
  assign start_erase = do_exec && !busy && write_latch_reg &&
                       (((cmd_reg == OP_PARAM_ERASE_SMALL || cmd_reg == OP_PARAM_ERASE_LARGE ||
                          cmd_reg == OP_SECTOR_ERASE) && lnk.byte_cnt == LEN_ADDR && !area_protected) ||
                        (cmd_reg == OP_BULK_ERASE && lnk.byte_cnt == LEN_SINGLE &&
                         prot_field == PROT_RESET)); // RQ12 RQ13
  assign op_done = busy && (op_cnt_reg == '0);

  // any self-timed operation starting now
  assign start_any = start_wrr || start_prog || start_erase;
  // one-byte frames are taken only while idle
  assign one_byte_cmd = do_exec && lnk.byte_cnt == LEN_SINGLE && !busy;
  assign clear_status_hit = one_byte_cmd && (cmd_reg == OP_CLEAR_STATUS);

  // duration of the operation being started
  always_comb begin
    op_len = OP_CNT_W'(WRR_CYCLES - 1);
    if (start_prog) begin
      op_len = OP_CNT_W'(PROG_CYCLES - 1);
    end else if (start_erase) begin
      op_len = OP_CNT_W'(ERASE_CYCLES - 1);
    end
  end

  // instruction byte, emptied at each frame start
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cmd_reg <= 8'h00;
    end else if (lnk.frame_start) begin
      cmd_reg <= 8'h00;
    end else if (lnk.byte_valid && lnk.byte_cnt == LEN_SINGLE) begin
      cmd_reg <= lnk.rx_byte; // RQ25
    end
  end

  // address or register-write bytes after the instruction
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      addr_reg <= 24'h000000;
    end else if (lnk.byte_valid) begin
      case (lnk.byte_cnt)
        3'h2: addr_reg[23:16] <= lnk.rx_byte;
        3'h3: addr_reg[15:8] <= lnk.rx_byte;
        3'h4: addr_reg[7:0] <= lnk.rx_byte;
        default: ;
      endcase
    end
  end

  // register-write payload held until the self-timed cycle completes
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wrr_st_reg <= 8'h00;
      wrr_cf_reg <= 8'h00;
      wrr_both_reg <= 1'b0;
    end else if (start_wrr) begin
      wrr_st_reg <= addr_reg[23:16];
      wrr_cf_reg <= addr_reg[15:8];
      wrr_both_reg <= (lnk.byte_cnt == LEN_WRR_BOTH);
    end
  end

  // self-timed operation sequencer
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      op_state_reg <= OP_IDLE;
      op_cnt_reg <= '0;
    end else begin
      case (op_state_reg)
        OP_IDLE: begin
          if (start_any) begin
            op_state_reg <= OP_RUN; // RQ8
            op_cnt_reg <= op_len;
          end
        end
        OP_RUN: begin
          if (op_cnt_reg == '0) begin
            op_state_reg <= OP_IDLE;
          end else begin
            op_cnt_reg <= op_cnt_reg - OP_CNT_W'(1);
          end
        end
        default: op_state_reg <= OP_IDLE;
      endcase
    end
  end

  // kind of operation, kept for the completion checks
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      op_kind_reg <= OPK_REG;
    end else if (start_any) begin
      op_kind_reg <= start_prog ? OPK_PROG : (start_erase ? OPK_ERASE : OPK_REG);
    end
  end

  // write latch: set by write-enable, cleared by write-disable and on every completion
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      write_latch_reg <= 1'b0; // RQ3
    end else if (op_done) begin
      write_latch_reg <= 1'b0; // RQ3 RQ10
    end else if (one_byte_cmd) begin
      if (cmd_reg == OP_WRITE_ENABLE) begin
        write_latch_reg <= 1'b1; // RQ9
      end else if (cmd_reg == OP_WRITE_DISABLE) begin
        write_latch_reg <= 1'b0; // RQ1 RQ3 RQ26
      end
    end
  end

  // protect and write-disable bits, written only by a completed register write
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prot_nv_reg <= PROT_RESET; // RQ14
      prot_vol_reg <= PROT_RESET; // RQ14
      reg_write_disable_reg <= 1'b0;
    end else if (op_done && op_kind_reg == OPK_REG) begin
      // locked mode already refused the write at its start
      prot_vol_reg <= wrr_st_reg[ST_PROT_MSB:ST_PROT_LSB]; // RQ12 RQ18
      if (!cfg_reg[CF_PROT_VOLATILITY]) begin
        prot_nv_reg <= wrr_st_reg[ST_PROT_MSB:ST_PROT_LSB]; // RQ11
      end
      reg_write_disable_reg <= wrr_st_reg[ST_REG_WRITE_DISABLE];
    end
  end

  // configuration bits, loaded only by a completed three-byte register write
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_reg <= CF_RESET; // RQ21
    end else if (op_done && op_kind_reg == OPK_REG && wrr_both_reg) begin
      cfg_reg <= wrr_cf_reg & CF_MASK; // RQ18 RQ23
    end
  end

  // program error: set on failed completion, cleared by clear-status, set wins
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prog_err_reg <= 1'b0;
    end else if (op_done && op_kind_reg == OPK_PROG && PROG_FAIL_I) begin
      prog_err_reg <= 1'b1; // RQ16 RQ19
    end else if (clear_status_hit) begin
      prog_err_reg <= 1'b0; // RQ16
    end
  end

  // erase error: same scheme for erase completions
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      erase_err_reg <= 1'b0;
    end else if (op_done && op_kind_reg == OPK_ERASE && ERASE_FAIL_I) begin
      erase_err_reg <= 1'b1; // RQ15 RQ19
    end else if (clear_status_hit) begin
      erase_err_reg <= 1'b0; // RQ15
    end
  end

  // read mode chosen by the first byte, accepted even while busy
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_mode_reg <= RD_NONE;
    end else if (lnk.frame_start || lnk.frame_end) begin
      rd_mode_reg <= RD_NONE;
    end else if (lnk.byte_valid && lnk.byte_cnt == LEN_SINGLE) begin
      case (lnk.rx_byte)
        OP_STATUS_READ: rd_mode_reg <= RD_STATUS; // RQ4
        OP_CONFIG_READ: rd_mode_reg <= RD_CONFIG; // RQ20
        default: rd_mode_reg <= RD_NONE;
      endcase
    end
  end

  // serial output: reload a fresh snapshot every byte, msb first, on falling clock
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tx_cnt_reg <= 3'h0;
      tx_shift_reg <= 7'h00;
      SO_O <= 1'b0;
      SO_OE_O <= 1'b0;
    end else if (lnk.frame_end || lnk.frame_start) begin
      tx_cnt_reg <= 3'h0;
      SO_OE_O <= 1'b0; // RQ25
    end else if (lnk.sck_fall && rd_mode_reg != RD_NONE) begin
      SO_OE_O <= 1'b1;
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      if (tx_cnt_reg == 3'h0) begin
        if (rd_mode_reg == RD_STATUS) begin
          SO_O <= status_byte[7]; // RQ5
          tx_shift_reg <= status_byte[6:0]; // RQ5
        end else begin
          SO_O <= config_byte[7]; // RQ20
          tx_shift_reg <= config_byte[6:0];
        end
      end else begin
        SO_O <= tx_shift_reg[6]; // RQ25
        tx_shift_reg <= {tx_shift_reg[5:0], 1'b0};
      end
    end
  end

  // busy mirrored on a pin for the array side
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BUSY_O <= 1'b0;
    end else begin
      BUSY_O <= start_any || (busy && !op_done);
    end
  end

endmodule
`default_nettype wire

//--- hw/sfg_spi_rx.sv
// sfg_spi_rx: synchronises the serial pins and turns mode-0 frames into byte events.
// assumes: serial clock far slower than the system clock.
`timescale 1ns/1ps
`default_nettype none
module sfg_spi_rx
  import sfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  sfg_link_if.rx lnk
);

  logic [3:0] pin_raw;
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic sck_d_reg;
  logic cs_d_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic sck_rise;
  logic sck_fall;

  assign pin_raw = {wp_n_i, si_i, cs_n_i, sck_i};

  // two-stage synchroniser per pin
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_reg[i] <= 1'b1;
        sync_reg[i] <= 1'b1;
      end else begin
        meta_reg[i] <= pin_raw[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  assign sck_rise = sync_reg[0] & ~sck_d_reg & ~sync_reg[1];
  assign sck_fall = ~sync_reg[0] & sck_d_reg & ~sync_reg[1];

  // edge history
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sync_reg[0];
      cs_d_reg <= sync_reg[1];
    end
  end

  // msb-first shifting and byte counting
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      lnk.byte_valid <= 1'b0;
      lnk.rx_byte <= 8'h00;
      lnk.byte_cnt <= 3'h0;
    end else begin
      lnk.byte_valid <= 1'b0;
      if (sync_reg[1]) begin
        bit_cnt_reg <= 3'h0;
      end else if (lnk.frame_start) begin
        bit_cnt_reg <= 3'h0;
        lnk.byte_cnt <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        shift_reg <= {shift_reg[5:0], sync_reg[2]};
        if (bit_cnt_reg == 3'h7) begin
          lnk.byte_valid <= 1'b1;
          lnk.rx_byte <= {shift_reg, sync_reg[2]};
          if (lnk.byte_cnt != 3'h7) begin
            lnk.byte_cnt <= lnk.byte_cnt + 3'h1;
          end
        end
      end
    end
  end

  // frame events
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lnk.frame_start <= 1'b0;
      lnk.frame_end <= 1'b0;
      lnk.sck_fall <= 1'b0;
      lnk.aligned <= 1'b1;
      lnk.wp_n <= 1'b1;
    end else begin
      lnk.frame_start <= cs_d_reg & ~sync_reg[1];
      lnk.frame_end <= ~cs_d_reg & sync_reg[1];
      lnk.sck_fall <= sck_fall;
      lnk.aligned <= (bit_cnt_reg == 3'h0) && !sck_rise;
      lnk.wp_n <= sync_reg[3];
    end
  end

endmodule
`default_nettype wire

//--- verif/sfg_guard_assertions.sv
// sfg_guard_assertions: port-level checks of the guard's serial output and busy flag.
// assumes: bound to sfg_guard; host keeps chip select high >= 16 clocks between frames.
`timescale 1ns/1ps
`default_nettype none
module sfg_guard_assertions #(
  parameter int WRR_CYCLES = 1000,
  parameter int PROG_CYCLES = 2000,
  parameter int ERASE_CYCLES = 4000
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire logic WP_N_I,
  input wire logic PROG_FAIL_I,
  input wire logic ERASE_FAIL_I,
  input wire logic SO_O,
  input wire logic SO_OE_O,
  input wire logic BUSY_O
);
  localparam int MIN_A = (WRR_CYCLES < PROG_CYCLES) ? WRR_CYCLES : PROG_CYCLES;
  localparam int MIN_C = (MIN_A < ERASE_CYCLES) ? MIN_A : ERASE_CYCLES;
  localparam int MAX_A = (WRR_CYCLES > PROG_CYCLES) ? WRR_CYCLES : PROG_CYCLES;
  localparam int MAX_C = (MAX_A > ERASE_CYCLES) ? MAX_A : ERASE_CYCLES;
  logic [15:0] busy_cnt_reg;

  // length of the current busy period
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_cnt_reg <= 16'h0;
    end else if (BUSY_O) begin
      busy_cnt_reg <= busy_cnt_reg + 16'h1;
    end else begin
      busy_cnt_reg <= 16'h0;
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  // output driver only inside frames
  AST_OE_IDLE: assert property (CS_N_I [*8] |-> !SO_OE_O)
    else $error("output enabled outside a frame");
  AST_OE_EARLY: assert property ($fell(CS_N_I) |-> !SO_OE_O [*8])
    else $error("output enabled before instruction ends");
  AST_OE_FRAME: assert property ($rose(SO_OE_O) |-> !CS_N_I && !$past(CS_N_I, 8))
    else $error("output enabled without a full instruction");
  AST_SO_STABLE: assert property (SO_OE_O && SCK_I && $past(SCK_I, 3) |-> $stable(SO_O))
    else $error("serial output moved in high clock phase");
  // busy flag follows self-timed operations
  AST_BUSY_START: assert property ($rose(BUSY_O) |-> CS_N_I && $past(CS_N_I, 2))
    else $error("busy rose inside a frame");
  AST_BUSY_HOLD: assert property ($rose(BUSY_O) |=> BUSY_O [*8])
    else $error("busy pulse too short");
  AST_BUSY_LEN: assert property ($fell(BUSY_O) |-> busy_cnt_reg + 2 >= MIN_C && busy_cnt_reg <= MAX_C + 2)
    else $error("busy period length out of range");
  AST_BUSY_GAP: assert property ($fell(BUSY_O) |-> !BUSY_O [*8])
    else $error("busy restarted without a command");
endmodule
bind sfg_guard sfg_guard_assertions #(.WRR_CYCLES(WRR_CYCLES), .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) u_chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .SCK_I(SCK_I),
  .CS_N_I(CS_N_I), .SI_I(SI_I), .WP_N_I(WP_N_I), .PROG_FAIL_I(PROG_FAIL_I),
  .ERASE_FAIL_I(ERASE_FAIL_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O), .BUSY_O(BUSY_O));
`default_nettype wire

//--- verif/sfg_guard_tb.sv
// sfg_guard_tb: directed checks of status byte, write latch and protection.
// assumes: host model drives the serial pins; operations shortened to 200 clocks.
`timescale 1ns/1ps
`default_nettype none
module sfg_guard_tb
  import sfg_pkg::*;
;
  localparam int OPC = 200;
  localparam logic [7:0] WOPS [8] = '{OP_REGISTER_WRITE, OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM,
    OP_PARAM_ERASE_SMALL, OP_PARAM_ERASE_LARGE, OP_SECTOR_ERASE, OP_BULK_ERASE, OP_ONE_TIME_PROGRAM};
  localparam int WLEN [8] = '{16, 40, 40, 32, 32, 32, 8, 40};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic pfail = 1'b0;
  logic efail = 1'b0;
  wire sck;
  wire cs_n;
  wire si;
  wire so;
  wire so_oe;
  wire busy;
  int fail_count = 0;
  int compares = 0;
  logic [47:0] rx;

  always #25 mclk = ~mclk;

  sfg_guard #(.WRR_CYCLES(OPC), .PROG_CYCLES(OPC), .ERASE_CYCLES(OPC)) uut (.MCLK_I(mclk),
    .RST_N_I(rst_n), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si), .WP_N_I(wp_n), .PROG_FAIL_I(pfail),
    .ERASE_FAIL_I(efail), .SO_O(so), .SO_OE_O(so_oe), .BUSY_O(busy));
  sfg_host_model host (.clk_i(mclk), .so_i(so), .so_oe_i(so_oe), .sck_o(sck), .cs_n_o(cs_n),
    .si_o(si));

  // comparisons
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask

  // serial access helpers
  task automatic cmd(input logic [39:0] tx, input int nb);
    host.frame(tx, nb, 0, rx);
  endtask
  task automatic rd_status(input logic [7:0] exp);
    host.frame({32'h0, OP_STATUS_READ}, 8, 1, rx);
    check8(rx[7:0], exp, "status");
  endtask
  task automatic rd_config(input logic [7:0] exp);
    host.frame({32'h0, OP_CONFIG_READ}, 8, 1, rx);
    check8(rx[7:0], exp, "config");
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge mclk);
    check1(busy, 1'b0, "busy end");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    $display("unexpected at %0t: watchdog ran out", $time);
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    rd_status(8'h00);
    check1(so_oe, 1'b0, "output idle");
    rd_config(8'h00);
    cmd(OP_WRITE_ENABLE, 8);
    rd_status(8'h02);
    cmd({OP_WRITE_DISABLE, 8'h00}, 16);
    rd_status(8'h02);
    cmd(OP_WRITE_DISABLE, 8);
    rd_status(8'h00);
    for (int k = 0; k < 8; k++) begin
      cmd({WOPS[k], 32'h0} >> (40 - WLEN[k]), WLEN[k]);
      check1(busy, 1'b0, "write type without latch");
    end
    // status repeats while a register write runs
    cmd(OP_WRITE_ENABLE, 8);
    cmd({OP_REGISTER_WRITE, 8'h1C}, 16);
    host.frame({32'h0, OP_STATUS_READ}, 8, 6, rx);
    check8(rx[47:40], 8'h03, "status while busy");
    check8(rx[7:0], 8'h1C, "status after write");
    // protected array
    cmd(OP_WRITE_ENABLE, 8);
    cmd(OP_BULK_ERASE, 8);
    check1(busy, 1'b0, "bulk erase protected");
    pfail = 1'b1;
    cmd({OP_PAGE_PROGRAM, 32'h0}, 40);
    check1(busy, 1'b0, "program protected");
    rd_status(8'h1E);
    cmd({OP_REGISTER_WRITE, 16'h8000}, 24);
    check1(busy, 1'b1, "register write busy");
    rd_config(8'h00);
    wait_idle();
    rd_status(8'h80);
    // locked mode, then unlock by the pin
    wp_n = 1'b0;
    cmd(OP_WRITE_ENABLE, 8);
    cmd({OP_REGISTER_WRITE, 8'h00}, 16);
    check1(busy, 1'b0, "locked register write");
    rd_status(8'h82);
    wp_n = 1'b1;
    cmd({OP_REGISTER_WRITE, 8'h00}, 16);
    wait_idle();
    rd_status(8'h00);
    // failed program and erase, flags survive register write
    cmd(OP_WRITE_ENABLE, 8);
    cmd({OP_PAGE_PROGRAM, 32'h0}, 40);
    wait_idle();
    rd_status(8'h40);
    efail = 1'b1;
    cmd(OP_WRITE_ENABLE, 8);
    cmd({OP_SECTOR_ERASE, 24'h0}, 32);
    wait_idle();
    rd_status(8'h60);
    cmd(OP_WRITE_ENABLE, 8);
    cmd({OP_REGISTER_WRITE, 8'h00}, 16);
    wait_idle();
    rd_status(8'h60);
    pfail = 1'b0;
    efail = 1'b0;
    cmd(OP_CLEAR_STATUS, 8);
    rd_status(8'h00);
    // volatile protect copy leaves the stored one alone, then quad bit disables locked mode
    cmd(OP_WRITE_ENABLE, 8);
    cmd({OP_REGISTER_WRITE, 16'h800A}, 24);
    wait_idle();
    rd_config(8'h0A);
    cmd(OP_WRITE_ENABLE, 8);
    cmd({OP_REGISTER_WRITE, 16'h9C02}, 24);
    wait_idle();
    rd_status(8'h80);
    wp_n = 1'b0;
    cmd(OP_WRITE_ENABLE, 8);
    cmd({OP_REGISTER_WRITE, 16'h0000}, 24);
    wait_idle();
    rd_status(8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- verif/sfg_host_model.sv
// sfg_host_model: serial host sending mode-0 frames to the guard.
// assumes: clk_i is the 20 MHz clock; serial clock 400 ns, still between frames.
`timescale 1ns/1ps
`default_nettype none
module sfg_host_model (
  input wire logic clk_i,
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  localparam int HALF = 4;

  // idle pins
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // nb bits out msb first, then nr bytes in
  task automatic frame(input logic [39:0] tx, input int nb, input int nr, output logic [47:0] rx);
    rx = 48'h0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 0; i < nb + 8 * nr; i++) begin
      si_o = (i < nb) ? tx[nb - 1 - i] : ~si_o;
      repeat (HALF) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (HALF) @(negedge clk_i);
      if (i >= nb) begin
        rx = {rx[46:0], so_oe_i ? so_i : 1'bx};
      end
      sck_o = 1'b0;
    end
    repeat (HALF) @(negedge clk_i);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (4 * HALF) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire
